// >>> analog_comparator_asserts.sv
/* port checker for analog_comparator_ctrl; assumes one clock, sync active-low reset */
`timescale 1ns/10ps
module analog_comparator_asserts (
  // watched ports
  input wire logic aclk, aresetn, s_axi_bvalid, raw_compare_output, compare_pin_out,
  input wire logic compare_pin_oe_n, edge_irq, stop3_mode, stop3_wake,
  input wire analog_comparator_pkg::analog_ctrl_t analog_ctrl
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // irq rises only from a raw edge, as the bench never sets enable over a set flag
  property p_rst; $rose(aresetn) |-> analog_ctrl == '0 && compare_pin_oe_n && !edge_irq; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_gate; compare_pin_oe_n |-> !compare_pin_out; endproperty
  a_gate: assert property (p_gate) else $error("pin not gated");
  property p_off; !analog_ctrl.comparator_enable [*2] |-> !compare_pin_out; endproperty
  a_off: assert property (p_off) else $error("status while off");
  property p_follow; (!compare_pin_oe_n && !stop3_mode && $stable(raw_compare_output)) [*4]
    |-> compare_pin_out == raw_compare_output; endproperty
  a_follow: assert property (p_follow) else $error("status stale");
  property p_wake; !stop3_mode |-> !stop3_wake; endproperty
  a_wake: assert property (p_wake) else $error("wake outside stop3");
  property p_quiet; stop3_mode [*5] |-> $stable(edge_irq); endproperty
  a_quiet: assert property (p_quiet) else $error("flag in stop3");
  property p_clear; $fell(edge_irq) |-> $past(s_axi_bvalid); endproperty
  a_clear: assert property (p_clear) else $error("flag lost");
  property p_lag; $rose(edge_irq) |-> $past(raw_compare_output, 4) != $past(raw_compare_output, 5); endproperty
  a_lag: assert property (p_lag) else $error("flag lag");
  c_irq: cover property ($rose(edge_irq));
  c_wake: cover property ($rose(stop3_wake));
  c_pin: cover property (!compare_pin_oe_n && compare_pin_out);
endmodule
bind analog_comparator_ctrl analog_comparator_asserts analog_comparator_asserts_inst (.*);

// >>> analog_comparator_ctrl.sv
/*
  Register file and digital control for an analog comparator with a 6-bit reference DAC,
  reached over AXI4-Lite. Drives the analog macro's settings, synchronises its output,
  raises the edge flag and interrupt request, and asks for wake-up while in stop3.
  Assumes the macro's raw output is asynchronous, and that stop3_mode is high while the
  bus clock is about to be or is gated off.
*/
`timescale 1ns/10ps
module analog_comparator_ctrl (
  // clock and reset
  input  wire logic                                          aclk,
  input  wire logic                                          aresetn,
  // axi4-lite write address
  input  wire logic [analog_comparator_pkg::ADDR_W-1:0]      s_axi_awaddr,
  input  wire logic [2:0]                                    s_axi_awprot,
  input  wire logic                                          s_axi_awvalid,
  output logic                                               s_axi_awready,
  // axi4-lite write data
  input  wire logic [analog_comparator_pkg::DATA_W-1:0]      s_axi_wdata,
  input  wire logic [analog_comparator_pkg::STRB_W-1:0]      s_axi_wstrb,
  input  wire logic                                          s_axi_wvalid,
  output logic                                               s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                                         s_axi_bresp,
  output logic                                               s_axi_bvalid,
  input  wire logic                                          s_axi_bready,
  // axi4-lite read address
  input  wire logic [analog_comparator_pkg::ADDR_W-1:0]      s_axi_araddr,
  input  wire logic [2:0]                                    s_axi_arprot,
  input  wire logic                                          s_axi_arvalid,
  output logic                                               s_axi_arready,
  // axi4-lite read data
  output logic [analog_comparator_pkg::DATA_W-1:0]           s_axi_rdata,
  output logic [1:0]                                         s_axi_rresp,
  output logic                                               s_axi_rvalid,
  input  wire logic                                          s_axi_rready,
  // analog macro
  output analog_comparator_pkg::analog_ctrl_t                analog_ctrl,
  input  wire logic                                          raw_compare_output,
  // pad and system
  output logic                                               compare_pin_out,
  output logic                                               compare_pin_oe_n,
  output logic                                               edge_irq,
  input  wire logic                                          stop3_mode,
  output logic                                               stop3_wake
);

  // register id from a byte address, shared by the read and write paths
  function automatic analog_comparator_pkg::reg_id_t decode_reg(
    input logic [analog_comparator_pkg::ADDR_W-1:0] addr
  );
    analog_comparator_pkg::reg_id_t id;
    id = analog_comparator_pkg::SEL_NONE;
    unique case (addr[analog_comparator_pkg::ADDR_W-1:2])
      analog_comparator_pkg::IDX_CONTROL_STATUS:   id = analog_comparator_pkg::SEL_CONTROL_STATUS;
      analog_comparator_pkg::IDX_INPUT_SELECT:     id = analog_comparator_pkg::SEL_INPUT_SELECT;
      analog_comparator_pkg::IDX_DAC_CONTROL:      id = analog_comparator_pkg::SEL_DAC_CONTROL;
      analog_comparator_pkg::IDX_INPUT_PIN_ENABLE: id = analog_comparator_pkg::SEL_INPUT_PIN_ENABLE;
      default:                                     id = analog_comparator_pkg::SEL_NONE;
    endcase
    return id;
  endfunction

  // control_status storage
  logic                              edge_flag;
  logic                              edge_interrupt_enable;
  logic                              output_pin_enable;
  analog_comparator_pkg::edge_mode_t edge_mode;

  // write channel holding
  logic [analog_comparator_pkg::ADDR_W-1:0] aw_addr;
  logic                                     aw_held;
  logic [analog_comparator_pkg::DATA_W-1:0] w_data;
  logic [analog_comparator_pkg::STRB_W-1:0] w_strb;
  logic                                     w_held;
  logic                                     write_fire;
  analog_comparator_pkg::reg_id_t           write_id;
  logic                                     low_lane;
  logic [7:0]                               wbyte;

  // read path
  analog_comparator_pkg::reg_id_t           read_id;
  logic [7:0]                               next_rbyte;

  // comparator result
  logic synced_level;
  logic valid_edge;
  logic output_status;
  logic detect_enable;
  logic stop_level;

  // write strobes
  logic wr_control_status;
  logic wr_input_select;
  logic wr_dac_control;
  logic wr_input_pin_enable;

  // a write is done once both halves are held and no response is still pending
  assign write_fire = aw_held & w_held & ~s_axi_bvalid;
  assign write_id   = decode_reg(aw_addr);
  assign low_lane   = w_strb[0];
  assign wbyte      = w_data[7:0];

  assign wr_control_status   = write_fire & low_lane & (write_id == analog_comparator_pkg::SEL_CONTROL_STATUS);
  assign wr_input_select     = write_fire & low_lane & (write_id == analog_comparator_pkg::SEL_INPUT_SELECT);
  assign wr_dac_control      = write_fire & low_lane & (write_id == analog_comparator_pkg::SEL_DAC_CONTROL);
  assign wr_input_pin_enable = write_fire & low_lane & (write_id == analog_comparator_pkg::SEL_INPUT_PIN_ENABLE);

  // write address acceptance; address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_held       <= 1'b0;
      aw_addr       <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_held       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      aw_held       <= 1'b0;
    end
  end

  // write data acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_held       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_held       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
      w_held       <= 1'b0;
    end
  end

  // write response; unmapped addresses answer slverr and change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= analog_comparator_pkg::RESP_OKAY;
    end else if (write_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (write_id == analog_comparator_pkg::SEL_NONE) ? analog_comparator_pkg::RESP_SLVERR
                                                                    : analog_comparator_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control_status writable fields; the flag is handled apart
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_ctrl.comparator_enable <=
        analog_comparator_pkg::CONTROL_STATUS_RESET[analog_comparator_pkg::CS_ENABLE_BIT];
      analog_ctrl.hysteresis_select <= analog_comparator_pkg::CONTROL_STATUS_RESET[analog_comparator_pkg::CS_HYST_BIT];
      edge_interrupt_enable         <= analog_comparator_pkg::CONTROL_STATUS_RESET[analog_comparator_pkg::CS_IE_BIT];
      output_pin_enable             <= analog_comparator_pkg::CONTROL_STATUS_RESET[analog_comparator_pkg::CS_OPE_BIT];
      edge_mode <= analog_comparator_pkg::edge_mode_t'(
                   analog_comparator_pkg::CONTROL_STATUS_RESET[analog_comparator_pkg::CS_MODE_LSB +: 2]);
    end else if (wr_control_status) begin
      analog_ctrl.comparator_enable <= wbyte[analog_comparator_pkg::CS_ENABLE_BIT];
      analog_ctrl.hysteresis_select <= wbyte[analog_comparator_pkg::CS_HYST_BIT];
      edge_interrupt_enable         <= wbyte[analog_comparator_pkg::CS_IE_BIT];
      output_pin_enable             <= wbyte[analog_comparator_pkg::CS_OPE_BIT];
      edge_mode <= analog_comparator_pkg::edge_mode_t'(wbyte[analog_comparator_pkg::CS_MODE_LSB +: 2]);
    end
  end

  // input selects; reserved bits are not stored, so they read back zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_ctrl.positive_input_select <= analog_comparator_pkg::input_source_t'(
        analog_comparator_pkg::INPUT_SELECT_RESET[analog_comparator_pkg::SEL_POS_LSB +: 2]);
      analog_ctrl.negative_input_select <= analog_comparator_pkg::input_source_t'(
        analog_comparator_pkg::INPUT_SELECT_RESET[analog_comparator_pkg::SEL_NEG_LSB +: 2]);
    end else if (wr_input_select) begin
      analog_ctrl.positive_input_select <= analog_comparator_pkg::input_source_t'(
        wbyte[analog_comparator_pkg::SEL_POS_LSB +: 2]);
      analog_ctrl.negative_input_select <= analog_comparator_pkg::input_source_t'(
        wbyte[analog_comparator_pkg::SEL_NEG_LSB +: 2]);
    end
  end

  // dac settings; level code goes to the macro as written, which adds the one step itself
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_ctrl.dac_output_enable    <=
        analog_comparator_pkg::DAC_CONTROL_RESET[analog_comparator_pkg::DAC_EN_BIT];
      analog_ctrl.dac_reference_select <= analog_comparator_pkg::DAC_CONTROL_RESET[analog_comparator_pkg::DAC_REF_BIT];
      analog_ctrl.dac_level <= analog_comparator_pkg::DAC_CONTROL_RESET[analog_comparator_pkg::DAC_LEVEL_LSB +: 6];
    end else if (wr_dac_control) begin
      analog_ctrl.dac_output_enable    <= wbyte[analog_comparator_pkg::DAC_EN_BIT];
      analog_ctrl.dac_reference_select <= wbyte[analog_comparator_pkg::DAC_REF_BIT];
      analog_ctrl.dac_level            <= wbyte[analog_comparator_pkg::DAC_LEVEL_LSB +: 6];
    end
  end

  // external pin gating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_ctrl.input_pin_enables <= analog_comparator_pkg::INPUT_PIN_ENABLE_RESET[analog_comparator_pkg::PIN_EN_LSB +: 3];
    end else if (wr_input_pin_enable) begin
      analog_ctrl.input_pin_enables <= wbyte[analog_comparator_pkg::PIN_EN_LSB +: 3];
    end
  end

  // detection only while enabled and the bus clock is trusted to run
  assign detect_enable = analog_ctrl.comparator_enable & ~stop3_mode;

  compare_sync_edge u_sync_edge (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .raw_compare_output (raw_compare_output),
    .detect_enable      (detect_enable),
    .edge_mode          (edge_mode),
    .synced_level       (synced_level),
    .valid_edge         (valid_edge)
  );

  // status follows the synchronised result, zero while disabled
  assign output_status = analog_ctrl.comparator_enable & synced_level;

  // edge flag: set wins over a clearing write in the same cycle; writing one does nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_flag <= analog_comparator_pkg::CONTROL_STATUS_RESET[analog_comparator_pkg::CS_FLAG_BIT];
    end else if (valid_edge) begin
      edge_flag <= 1'b1;
    end else if (wr_control_status && !wbyte[analog_comparator_pkg::CS_FLAG_BIT]) begin
      edge_flag <= 1'b0;
    end
  end

  // interrupt request to the cpu
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edge_irq <= 1'b0;
    end else begin
      edge_irq <= edge_flag & edge_interrupt_enable;
    end
  end

  // output pad; pad is released rather than driven low when not enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_pin_out  <= 1'b0;
      compare_pin_oe_n <= 1'b1;
    end else begin
      compare_pin_out  <= output_pin_enable & output_status;
      compare_pin_oe_n <= ~(output_pin_enable & analog_ctrl.comparator_enable);
    end
  end

  // level seen last while the clock ran; status itself is simply left stale during stop3
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_level <= 1'b0;
    end else if (!stop3_mode) begin
      stop_level <= synced_level;
    end
  end

  // wake must work with no clock, so it is built from the raw level against the saved one;
  // it follows the raw level, dropping if that level returns, and is forced low when stop3 ends; then the flag path takes over
  always_comb begin
    stop3_wake = 1'b0;
    if (stop3_mode && analog_ctrl.comparator_enable) begin
      unique case (edge_mode)
        analog_comparator_pkg::EDGE_RISING:    stop3_wake = raw_compare_output & ~stop_level;
        analog_comparator_pkg::EDGE_BOTH:      stop3_wake = raw_compare_output ^ stop_level;
        analog_comparator_pkg::EDGE_FALLING,
        analog_comparator_pkg::EDGE_FALLING_2: stop3_wake = ~raw_compare_output & stop_level;
      endcase
    end
  end

  // read mux
  always_comb begin
    read_id    = decode_reg(s_axi_araddr);
    next_rbyte = 8'h00;
    unique case (read_id)
      analog_comparator_pkg::SEL_CONTROL_STATUS: begin
        next_rbyte[analog_comparator_pkg::CS_ENABLE_BIT]      = analog_ctrl.comparator_enable;
        next_rbyte[analog_comparator_pkg::CS_HYST_BIT]        = analog_ctrl.hysteresis_select;
        next_rbyte[analog_comparator_pkg::CS_FLAG_BIT]        = edge_flag;
        next_rbyte[analog_comparator_pkg::CS_IE_BIT]          = edge_interrupt_enable;
        next_rbyte[analog_comparator_pkg::CS_STATUS_BIT]      = output_status;
        next_rbyte[analog_comparator_pkg::CS_OPE_BIT]         = output_pin_enable;
        next_rbyte[analog_comparator_pkg::CS_MODE_LSB +: 2]   = edge_mode;
      end
      analog_comparator_pkg::SEL_INPUT_SELECT: begin
        next_rbyte[analog_comparator_pkg::SEL_POS_LSB +: 2]   = analog_ctrl.positive_input_select;
        next_rbyte[analog_comparator_pkg::SEL_NEG_LSB +: 2]   = analog_ctrl.negative_input_select;
      end
      analog_comparator_pkg::SEL_DAC_CONTROL: begin
        next_rbyte[analog_comparator_pkg::DAC_EN_BIT]         = analog_ctrl.dac_output_enable;
        next_rbyte[analog_comparator_pkg::DAC_REF_BIT]        = analog_ctrl.dac_reference_select;
        next_rbyte[analog_comparator_pkg::DAC_LEVEL_LSB +: 6] = analog_ctrl.dac_level;
      end
      analog_comparator_pkg::SEL_INPUT_PIN_ENABLE: begin
        next_rbyte[analog_comparator_pkg::PIN_EN_LSB +: 3]    = analog_ctrl.input_pin_enables;
      end
      analog_comparator_pkg::SEL_NONE: begin
        next_rbyte = 8'h00;
      end
    endcase
  end

  // read address acceptance and data; one read in flight at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= analog_comparator_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, next_rbyte};
      s_axi_rresp   <= (read_id == analog_comparator_pkg::SEL_NONE) ? analog_comparator_pkg::RESP_SLVERR
                                                                    : analog_comparator_pkg::RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

endmodule

// >>> analog_comparator_ctrl_tb.sv
/* bench for analog_comparator_ctrl; assumes the macro model and the bound checker */
`timescale 1ns/10ps
module analog_comparator_ctrl_tb;
  logic aclk = 1'h0, aresetn = 1'h0, diff = 1'h0, stop3_mode = 1'h0, s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, v;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, raw_compare_output, edge_irq;
  wire compare_pin_out, compare_pin_oe_n, stop3_wake;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire analog_comparator_pkg::analog_ctrl_t analog_ctrl;
  int n_fail = 0, comparisons = 0, cycles = 0;
  logic [9:0] notes[$];
  analog_comparator_ctrl analog_comparator_ctrl_inst (.*);
  analog_macro_model analog_macro_model_inst (.*);
  always #5 aclk = ~aclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: saw %h not %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("%0d mismatches, %0d comparisons", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one bus cycle, answer noted; indices outside 2C..2F answer with an error
  task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
    notes.push_back({(i > 6'h2B && i < 6'h30) ? 2'h0 : 2'h2, w ? 8'h00 : d});
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {i, 2'h0, i, 2'h0, 24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
    do @(posedge aclk); while (!(w ? s_axi_awready && s_axi_wready : s_axi_arready));
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 3'h0;
    do @(posedge aclk); while (!(s_axi_bvalid || s_axi_rvalid));
  endtask
  // answers against the oldest note, and the hang limit
  always @(posedge aclk) begin
    if (s_axi_bvalid) check({s_axi_bresp, 8'h00}, notes.pop_front());
    if (s_axi_rvalid) check({|s_axi_rdata[31:8], s_axi_rresp, s_axi_rdata[7:0]}, notes.pop_front());
    if (++cycles == 4000) begin
      n_fail++;
      complete_run();
    end
  end
  // registers, every edge mode, stop3 wake, pin gating
  initial begin
    v = 8'($urandom(32'h583C)) | 8'h80; // dac on, since it feeds both inputs
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    for (int i = 43; i < 49; i++) bus(1'h0, 6'(i), 8'h00);
    bus(1'h1, 6'h2D, 8'hFF);
    bus(1'h0, 6'h2D, 8'h33);
    s_axi_wstrb <= 4'h0;
    bus(1'h1, 6'h2D, 8'h00);
    s_axi_wstrb <= 4'hF;
    bus(1'h1, 6'h2F, 8'hFF);
    bus(1'h0, 6'h2F, 8'h07);
    bus(1'h1, 6'h2E, v & 8'h7F);
    bus(1'h1, 6'h2E, v);
    bus(1'h0, 6'h2E, v);
    check(analog_ctrl, {6'h0F, v, 3'h7});
    bus(1'h1, 6'h2B, v);
    bus(1'h1, 6'h2C, 8'h80);
    repeat (4) @(posedge aclk);
    for (int m = 0; m < 4; m++) begin
      bus(1'h1, 6'h2C, {6'h24, 2'(m)});
      bus(1'h1, 6'h2C, {6'h2C, 2'(m)});
      bus(1'h0, 6'h2C, {6'h24, 2'(m)});
      diff <= 1'h1;
      repeat (6) @(posedge aclk);
      bus(1'h0, 6'h2C, {m[0] ? 6'h2E : 6'h26, 2'(m)});
      check(edge_irq, m[0]);
      bus(1'h1, 6'h2C, {6'h24, 2'(m)});
      diff <= 1'h0;
      repeat (6) @(posedge aclk);
      bus(1'h0, 6'h2C, {m == 1 ? 6'h24 : 6'h2C, 2'(m)});
    end
    bus(1'h1, 6'h2C, 8'hD7);
    stop3_mode <= 1'h1;
    repeat (3) @(posedge aclk);
    diff <= 1'h1;
    repeat (6) @(posedge aclk);
    check(stop3_wake, 1'h1);
    stop3_mode <= 1'h0;
    repeat (4) @(posedge aclk);
    bus(1'h0, 6'h2C, 8'hDF);
    check({compare_pin_oe_n, compare_pin_out}, 2'h1);
    complete_run();
  end
endmodule

// >>> analog_comparator_pkg.sv
/*
  Shared constants and types for the analog comparator and reference DAC control block:
  register indices, field positions, reset values, response codes and the packed control bundle.
  Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address; every register is one
  aligned word at four times its index, and only the low byte carries data.
*/
package analog_comparator_pkg;

  // bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int REG_W  = 8;

  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_CONTROL_STATUS   = 6'h2C;
  localparam logic [5:0] IDX_INPUT_SELECT     = 6'h2D;
  localparam logic [5:0] IDX_DAC_CONTROL      = 6'h2E;
  localparam logic [5:0] IDX_INPUT_PIN_ENABLE = 6'h2F;

  // control_status fields
  localparam int CS_ENABLE_BIT  = 7;
  localparam int CS_HYST_BIT    = 6;
  localparam int CS_FLAG_BIT    = 5;
  localparam int CS_IE_BIT      = 4;
  localparam int CS_STATUS_BIT  = 3;
  localparam int CS_OPE_BIT     = 2;
  localparam int CS_MODE_LSB    = 0;

  // input_select fields
  localparam int SEL_POS_LSB = 4;
  localparam int SEL_NEG_LSB = 0;

  // dac_control fields
  localparam int DAC_EN_BIT    = 7;
  localparam int DAC_REF_BIT   = 6;
  localparam int DAC_LEVEL_LSB = 0;

  // input_pin_enable field
  localparam int PIN_EN_LSB = 0;

  // reset values
  localparam logic [7:0] CONTROL_STATUS_RESET   = 8'h00;
  localparam logic [7:0] INPUT_SELECT_RESET     = 8'h00;
  localparam logic [7:0] DAC_CONTROL_RESET      = 8'h00;
  localparam logic [7:0] INPUT_PIN_ENABLE_RESET = 8'h00;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // input source codes, shared by both selects
  typedef enum logic [1:0] {
    SRC_EXTERNAL_0 = 2'h0,
    SRC_EXTERNAL_1 = 2'h1,
    SRC_RESERVED   = 2'h2,
    SRC_DAC_OUTPUT = 2'h3
  } input_source_t;

  // edge sensitivity codes
  typedef enum logic [1:0] {
    EDGE_FALLING   = 2'h0,
    EDGE_RISING    = 2'h1,
    EDGE_FALLING_2 = 2'h2,
    EDGE_BOTH      = 2'h3
  } edge_mode_t;

  // register selected by an address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CONTROL_STATUS,
    SEL_INPUT_SELECT,
    SEL_DAC_CONTROL,
    SEL_INPUT_PIN_ENABLE
  } reg_id_t;

  // settings that go to the analog macro
  typedef struct packed {
    logic          comparator_enable;
    logic          hysteresis_select;
    input_source_t positive_input_select;
    input_source_t negative_input_select;
    logic          dac_output_enable;
    logic          dac_reference_select;
    logic [5:0]    dac_level;
    logic [2:0]    input_pin_enables;
  } analog_ctrl_t;

endpackage

// >>> analog_macro_model.sv
/* analog macro stand-in; assumes diff is the sign of the input difference */
`timescale 1ns/10ps
module analog_macro_model (
  // bus clock, settings, wanted result
  input wire logic aclk, diff,
  input wire analog_comparator_pkg::analog_ctrl_t analog_ctrl,
  output logic raw_compare_output = 1'h0
);
  // moves off the bus edge; an idle comparator shows no steady level
  always @(negedge aclk) raw_compare_output <= analog_ctrl.comparator_enable ? diff : !raw_compare_output;
endmodule

// >>> compare_sync_edge.sv
/*
  Brings the raw comparator output into the bus clock domain and detects valid edges.
  Assumes the raw output is asynchronous to aclk; the first stage feeds only the second.
*/
`timescale 1ns/10ps
module compare_sync_edge (
  // clock and reset
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  // comparator side
  input  wire logic                              raw_compare_output,
  // control
  input  wire logic                              detect_enable,
  input  wire analog_comparator_pkg::edge_mode_t edge_mode,
  // results
  output logic                                   synced_level,
  output logic                                   valid_edge
);

  logic sync_first;
  logic sync_prev;
  logic rise;
  logic fall;

  // two-stage synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_first   <= 1'b0;
      synced_level <= 1'b0;
    end else begin
      sync_first   <= raw_compare_output;
      synced_level <= sync_first;
    end
  end

  // previous sample tracks the live one while detection is off, so no stale edge shows up later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_prev <= 1'b0;
    end else begin
      sync_prev <= synced_level;
    end
  end

  assign rise = detect_enable & synced_level & ~sync_prev;
  assign fall = detect_enable & ~synced_level & sync_prev;

  // edge qualification by mode
  always_comb begin
    valid_edge = 1'b0;
    unique case (edge_mode)
      analog_comparator_pkg::EDGE_FALLING:   valid_edge = fall;
      analog_comparator_pkg::EDGE_FALLING_2: valid_edge = fall;
      analog_comparator_pkg::EDGE_RISING:    valid_edge = rise;
      analog_comparator_pkg::EDGE_BOTH:      valid_edge = rise | fall;
    endcase
  end

endmodule
